// ---- hdl/tsi_pkg.sv ----
// ----------------------------------------------------------------------------
// Shared constants of the track segment intake link.
// ----------------------------------------------------------------------------
package tsi_pkg;
    localparam int WORD_W = 48;
    localparam int SIDE_W = 32;
    localparam int ADDR_W = WORD_W - SIDE_W;
    localparam int LAYER_W = 2;
    localparam int CARD_W = 4;
    localparam int NUM_LAYERS = 4;
    localparam int SEG_CAP = 128;
    localparam int CNT_W = 8;
    localparam int INNER_CARDS = 6;
    localparam int OUTER_CARDS = 12;
    localparam int EVT_CNT_W = 16;
    // Decision deadline after the keep signal, in nanoseconds, and the core clock period.
    localparam int DEADLINE_NS = 19800;
    localparam int CORE_PERIOD_NS = 50;
    // A longest time rounds down to whole cycles.
    localparam int DEADLINE_CYC = DEADLINE_NS / CORE_PERIOD_NS;
    // Two synchroniser stages plus the edge detect and the output flop eat into the deadline.
    localparam int SYNC_LAT = 4;
    localparam int DECIDE_CYC = DEADLINE_CYC - SYNC_LAT;
    localparam int TIMER_W = 9;
    // Link clock divider: core clock cycles per link clock phase.
    localparam int LINK_HALF_CYC = 1;
    localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
endpackage : tsi_pkg

// ---- hdl/tsi_link_if.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// Link between segment source side and the trigger card.
// ----------------------------------------------------------------------------
interface tsi_link_if;
    logic link_clk;
    logic [tsi_pkg::WORD_W-1:0] link_word;
    logic link_valid;
    logic [tsi_pkg::LAYER_W-1:0] link_layer;
    logic [tsi_pkg::CARD_W-1:0] link_card;
    logic first_level_keep;
    logic abort_clear;
    logic run_start;
    logic trig_keep;
    logic trig_reject;

    modport dev (
        input link_clk, link_word, link_valid, link_layer, link_card,
        input first_level_keep, abort_clear, run_start,
        output trig_keep, trig_reject
    );
    modport src (
        output link_clk, link_word, link_valid, link_layer, link_card,
        output first_level_keep, abort_clear, run_start,
        input trig_keep, trig_reject
    );
endinterface : tsi_link_if
`default_nettype wire

// ---- hdl/tsi_intake.sv ----
// Functional notes
// - Start event processing only after keep.
// - Decision out within 19.8 us of keep.
// - Accept at most 128 segments per layer.
// - Inner layers 6 cards, fourth 12.
// - Any order, any spread across cards.
// - Links carry 48-bit words plus clock.
// - Transmitter keeps link clock running always.
// - Explicit valid bit separates zero from idle.
// - Side words merged, tagged with address.
// - Abort finishes tasks, then soft reset.
// - Run start clears internal counters; only event_count here.
// - Trigger element outputs are plain single-ended.
// - Host readout only after a kept event.
// - Constant download only at run start.
`timescale 1ns/100ps
`default_nettype none
module tsi_intake (
    input wire logic core_clk,
    input wire logic nrst,
    tsi_link_if.dev link,
    input wire logic [tsi_pkg::SIDE_W-1:0] side_data,
    input wire logic side_valid,
    output logic side_ready,
    output logic [tsi_pkg::WORD_W-1:0] out_word,
    output logic out_valid,
    output logic out_is_side,
    output logic read_ok,
    output logic download_ok,
    output logic [tsi_pkg::EVT_CNT_W-1:0] event_count
);
    typedef enum {TSI_IDLE, TSI_COLLECT, TSI_KEPT, TSI_REJECTED} tsi_state_t;

    // ------------------------------------------------------------------------
    // Link domain.
    // ------------------------------------------------------------------------

    // Reset release is synchronised to the link clock so counters leave reset cleanly.
    logic lrst_meta;
    logic lrst_n;
    always_ff @(posedge link.link_clk or negedge nrst) begin
        if (!nrst) begin
            lrst_meta <= 1'b0;
            lrst_n <= 1'b0;
        end else begin
            lrst_meta <= 1'b1;
            lrst_n <= lrst_meta;
        end
    end

    // Event window from the core side, brought over by two flops.
    logic open_core;
    logic open_meta;
    logic open_sync;
    logic open_prev;
    always_ff @(posedge link.link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            open_meta <= 1'b0;
            open_sync <= 1'b0;
            open_prev <= 1'b0;
        end else begin
            open_meta <= open_core;
            open_sync <= open_meta;
            open_prev <= open_sync;
        end
    end

    // Any change of the window marks a new event or the end of one at its decision.
    logic evt_edge;
    assign evt_edge = open_sync ^ open_prev;

    // A source card index is legal only within its layer's population.
    function automatic logic card_ok(input logic [tsi_pkg::LAYER_W-1:0] layer,
                                     input logic [tsi_pkg::CARD_W-1:0] card);
        if (layer == 2'h3) begin
            card_ok = card < 4'(tsi_pkg::OUTER_CARDS);
        end else begin
            card_ok = card < 4'(tsi_pkg::INNER_CARDS);
        end
    endfunction : card_ok

    // Only marked words during an open event, from a legal card, count.
    logic seg_take;
    assign seg_take = link.link_valid && open_sync && card_ok(link.link_layer, link.link_card);

    logic [tsi_pkg::NUM_LAYERS-1:0] layer_full;
    logic [tsi_pkg::NUM_LAYERS-1:0] layer_seen;
    logic seg_accept;
    assign seg_accept = seg_take && !layer_full[link.link_layer];

    // Per-layer counters; arrival order and card spread do not matter.
    genvar gl;
    generate
        for (gl = 0; gl < tsi_pkg::NUM_LAYERS; gl++) begin : g_layer
            logic [tsi_pkg::CNT_W-1:0] seg_cnt;
            always_ff @(posedge link.link_clk or negedge lrst_n) begin
                if (!lrst_n) begin
                    seg_cnt <= tsi_pkg::CNT_RESET;
                end else if (evt_edge) begin
                    seg_cnt <= tsi_pkg::CNT_RESET;
                end else if (seg_accept && link.link_layer == 2'(gl)) begin
                    seg_cnt <= seg_cnt + 8'h01;
                end
            end
            assign layer_full[gl] = seg_cnt == 8'(tsi_pkg::SEG_CAP);
            assign layer_seen[gl] = seg_cnt != tsi_pkg::CNT_RESET;
        end
    endgenerate

    // Side words wait in a single hold slot; segments have priority on the output.
    logic hold_valid;
    logic [tsi_pkg::SIDE_W-1:0] hold_data;
    logic [tsi_pkg::ADDR_W-1:0] side_addr;
    logic side_emit;
    assign side_emit = hold_valid && !seg_accept;

    always_ff @(posedge link.link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            hold_valid <= 1'b0;
            hold_data <= '0;
        end else if (side_valid && side_ready) begin
            hold_valid <= 1'b1;
            hold_data <= side_data;
        end else if (side_emit) begin
            hold_valid <= 1'b0;
        end
    end

    // The ready flag mirrors a free slot, so a waiting word is never overwritten.
    always_ff @(posedge link.link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            side_ready <= 1'b0;
        end else begin
            side_ready <= !(hold_valid && !side_emit) && !(side_valid && side_ready);
        end
    end

    // Address counts side words of the event in order; a new event starts again at zero.
    always_ff @(posedge link.link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            side_addr <= tsi_pkg::ADDR_RESET;
        end else if (evt_edge) begin
            side_addr <= tsi_pkg::ADDR_RESET;
        end else if (side_emit) begin
            side_addr <= side_addr + 16'h0001;
        end
    end

    // Merged output stream.
    always_ff @(posedge link.link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            out_word <= '0;
            out_valid <= 1'b0;
            out_is_side <= 1'b0;
        end else if (seg_accept) begin
            out_word <= link.link_word;
            out_valid <= 1'b1;
            out_is_side <= 1'b0;
        end else if (side_emit) begin
            out_word <= {side_addr, hold_data};
            out_valid <= 1'b1;
            out_is_side <= 1'b1;
        end else begin
            out_valid <= 1'b0;
            out_is_side <= 1'b0;
        end
    end

    // All four layers holding segments is the level that the decision looks at.
    logic all_seen;
    always_ff @(posedge link.link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            all_seen <= 1'b0;
        end else begin
            all_seen <= &layer_seen;
        end
    end

    // ------------------------------------------------------------------------
    // Core domain.
    // ------------------------------------------------------------------------

    // Pins from the central trigger and the seen level cross on two flops each.
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic keep_prev;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
            keep_prev <= 1'b0;
        end else begin
            pin_meta <= {all_seen, link.run_start, link.abort_clear, link.first_level_keep};
            pin_sync <= pin_meta;
            keep_prev <= pin_sync[0];
        end
    end

    logic keep_rise;
    logic abort_lvl;
    logic run_lvl;
    logic seen_lvl;
    assign keep_rise = pin_sync[0] && !keep_prev;
    assign abort_lvl = pin_sync[1];
    assign run_lvl = pin_sync[2];
    assign seen_lvl = pin_sync[3];

    tsi_state_t state;
    tsi_state_t next_state;
    logic [tsi_pkg::TIMER_W-1:0] timer;
    logic abort_pend;
    logic decide;
    assign decide = state == TSI_COLLECT && timer == 9'(tsi_pkg::DECIDE_CYC);

    // Event sequence: an abort seen while collecting is held until the decision is out.
    always_comb begin
        next_state = state;
        case (state)
            TSI_IDLE: begin
                if (keep_rise && !abort_lvl && !run_lvl) begin
                    next_state = TSI_COLLECT;
                end
            end
            TSI_COLLECT: begin
                if (decide) begin
                    if (abort_pend || abort_lvl) begin
                        next_state = TSI_IDLE;
                    end else if (seen_lvl) begin
                        next_state = TSI_KEPT;
                    end else begin
                        next_state = TSI_REJECTED;
                    end
                end
            end
            TSI_KEPT, TSI_REJECTED: begin
                if (abort_lvl || run_lvl) begin
                    next_state = TSI_IDLE;
                end
            end
            default: next_state = TSI_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state <= TSI_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            timer <= '0;
        end else if (state == TSI_COLLECT) begin
            timer <= timer + 9'h001;
        end else begin
            timer <= '0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            abort_pend <= 1'b0;
        end else if (state == TSI_COLLECT) begin
            abort_pend <= abort_pend || abort_lvl;
        end else begin
            abort_pend <= 1'b0;
        end
    end

    // The event window feeds the link side; it closes at the decision, even when an abort arrives during collection.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            open_core <= 1'b0;
        end else begin
            open_core <= next_state == TSI_COLLECT;
        end
    end

    // Trigger elements are driven as plain levels from flops; the board drives the pins.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            link.trig_keep <= 1'b0;
            link.trig_reject <= 1'b0;
        end else begin
            link.trig_keep <= decide && !abort_pend && !abort_lvl && seen_lvl;
            link.trig_reject <= decide && (abort_pend || abort_lvl || !seen_lvl);
        end
    end

    // Readout gate follows a kept event only.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            read_ok <= 1'b0;
        end else begin
            read_ok <= next_state == TSI_KEPT;
        end
    end

    // Download window opens at run start and shuts on the first keep.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            download_ok <= 1'b0;
        end else if (run_lvl && state == TSI_IDLE) begin
            download_ok <= 1'b1;
        end else if (keep_rise) begin
            download_ok <= 1'b0;
        end
    end

    // Event counter, cleared at run start.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            event_count <= '0;
        end else if (run_lvl) begin
            event_count <= '0;
        end else if (decide) begin
            event_count <= event_count + 16'h0001;
        end
    end
endmodule : tsi_intake
`default_nettype wire

// ---- hdl/tsi_source.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// Source side: makes the link clock, sends segments, drives trigger pins.
// ----------------------------------------------------------------------------
module tsi_source (
    input wire logic core_clk,
    input wire logic nrst,
    tsi_link_if.src link,
    input wire logic [tsi_pkg::WORD_W-1:0] seg_word,
    input wire logic [tsi_pkg::LAYER_W-1:0] seg_layer,
    input wire logic [tsi_pkg::CARD_W-1:0] seg_card,
    input wire logic seg_valid,
    output logic seg_ready,
    input wire logic keep_req,
    input wire logic abort_req,
    input wire logic run_req,
    output logic got_keep,
    output logic got_reject
);
    // Link clock runs free from reset on, idle or not, so the receiver stays locked.
    logic [3:0] div_cnt;
    logic phase_end;
    assign phase_end = div_cnt == 4'(tsi_pkg::LINK_HALF_CYC - 1);
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            div_cnt <= 4'h0;
            link.link_clk <= 1'b0;
        end else if (phase_end) begin
            div_cnt <= 4'h0;
            link.link_clk <= !link.link_clk;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    // Words change as the link clock falls, half a link period before the sampling edge.
    logic launch;
    assign launch = phase_end && link.link_clk;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            seg_ready <= 1'b0;
        end else begin
            seg_ready <= phase_end && !link.link_clk;
        end
    end

    // Idle words carry a clear valid bit, so a zero word stays distinguishable.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            link.link_word <= '0;
            link.link_valid <= 1'b0;
            link.link_layer <= '0;
            link.link_card <= '0;
        end else if (launch) begin
            link.link_word <= seg_word;
            link.link_valid <= seg_valid && seg_ready;
            link.link_layer <= seg_layer;
            link.link_card <= seg_card;
        end
    end

    // Control pins come from flops.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            link.first_level_keep <= 1'b0;
            link.abort_clear <= 1'b0;
            link.run_start <= 1'b0;
        end else begin
            link.first_level_keep <= keep_req;
            link.abort_clear <= abort_req;
            link.run_start <= run_req;
        end
    end

    // Decision pulses arrive from the other card's clock; two flops, then edge detect.
    logic [1:0] dec_meta;
    logic [1:0] dec_sync;
    logic [1:0] dec_prev;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            dec_meta <= 2'h0;
            dec_sync <= 2'h0;
            dec_prev <= 2'h0;
            got_keep <= 1'b0;
            got_reject <= 1'b0;
        end else begin
            dec_meta <= {link.trig_reject, link.trig_keep};
            dec_sync <= dec_meta;
            dec_prev <= dec_sync;
            got_keep <= dec_sync[0] && !dec_prev[0];
            got_reject <= dec_sync[1] && !dec_prev[1];
        end
    end
endmodule : tsi_source
`default_nettype wire

// ---- verif/tsi_link_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// Checker on the link that joins the source end to the intake end.
// ----------------------------------------------------------------------------
module tsi_link_chk (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic link_clk,
    input wire logic first_level_keep,
    input wire logic abort_clear,
    input wire logic trig_keep,
    input wire logic trig_reject
);
    localparam int DEAD_CYC = 396;
    logic pend;
    logic link_prev;
    logic [1:0] stay_cnt;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // An event is pending from the keep rise until its verdict pulse.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pend <= 1'b0;
        end else if (trig_keep || trig_reject) begin
            pend <= 1'b0;
        end else if ($rose(first_level_keep)) begin
            pend <= 1'b1;
        end
    end

    // Counts core cycles in which the link clock held its level.
    // Two are tolerated so that a divider starting one cycle late is not flagged.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            link_prev <= 1'b0;
            stay_cnt <= 2'h0;
        end else begin
            link_prev <= link_clk;
            stay_cnt <= (link_clk == link_prev) ? stay_cnt + 2'h1 : 2'h0;
        end
    end

    sequence s_verdict;
        trig_keep || trig_reject;
    endsequence

    sequence s_new_event;
        $rose(first_level_keep);
    endsequence

    chk_deadline_met: assert property (s_new_event |-> ##[1:DEAD_CYC] s_verdict)
        else $error("decision missed its deadline after keep");
    chk_not_before_keep: assert property (s_verdict |-> pend)
        else $error("decision issued without a pending event");
    chk_single_verdict: assert property (!(trig_keep && trig_reject))
        else $error("keep and reject given together");
    chk_keep_pulse: assert property ($rose(trig_keep) |=> !trig_keep)
        else $error("keep verdict longer than one cycle");
    chk_reject_pulse: assert property (trig_reject |=> !trig_reject)
        else $error("reject verdict longer than one cycle");
    chk_abort_no_keep: assert property (abort_clear && $past(abort_clear, 4) |-> !trig_keep)
        else $error("keep verdict given during abort");
    chk_abort_verdict: assert property ($rose(abort_clear) && pend |-> ##[1:DEAD_CYC] trig_reject)
        else $error("abort did not close the event with a reject");
    chk_link_clk_runs: assert property (stay_cnt != 2'h3)
        else $error("link clock stopped");
endmodule : tsi_link_chk
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// Bench joining both ends across the link; drives the user sides.
// ----------------------------------------------------------------------------
module testbench;
    typedef struct {
        logic [tsi_pkg::LAYER_W-1:0] layer;
        logic [tsi_pkg::CARD_W-1:0] card;
        logic [tsi_pkg::WORD_W-1:0] word;
        logic accept;
    } tsi_row_t;
    // Card limits per layer; the first row is a valid all-zero word.
    tsi_row_t rows[8] = '{
        '{2'h0, 4'h0, 48'h000000000000, 1'b1}, '{2'h0, 4'h5, 48'hFFFFFFFFFFFF, 1'b1},
        '{2'h0, 4'h6, 48'h123456789ABC, 1'b0}, '{2'h1, 4'h5, 48'h111111111111, 1'b1},
        '{2'h2, 4'h3, 48'h222222222222, 1'b1}, '{2'h2, 4'h7, 48'h333333333333, 1'b0},
        '{2'h3, 4'hB, 48'h444444444444, 1'b1}, '{2'h3, 4'hC, 48'h555555555555, 1'b0}};
    logic core_clk, nrst, seg_valid, seg_ready, keep_req, abort_req, run_req;
    logic got_keep, got_reject, side_valid, side_ready, out_valid, out_is_side;
    logic read_ok, download_ok, kept;
    logic [tsi_pkg::WORD_W-1:0] seg_word, out_word;
    logic [tsi_pkg::LAYER_W-1:0] seg_layer;
    logic [tsi_pkg::CARD_W-1:0] seg_card;
    logic [tsi_pkg::SIDE_W-1:0] side_data;
    logic [tsi_pkg::EVT_CNT_W-1:0] event_count;
    logic [tsi_pkg::WORD_W-1:0] seg_q[$], side_q[$], wire_q[$];
    int num_errors, tests_run, cyc_cnt, mark, link_edges, i;

    tsi_link_if tsi_link_if_inst ();
    tsi_source tsi_source_inst (.core_clk(core_clk), .nrst(nrst), .link(tsi_link_if_inst),
        .seg_word(seg_word), .seg_layer(seg_layer), .seg_card(seg_card),
        .seg_valid(seg_valid), .seg_ready(seg_ready), .keep_req(keep_req),
        .abort_req(abort_req), .run_req(run_req), .got_keep(got_keep), .got_reject(got_reject));
    tsi_intake tsi_intake_inst (.core_clk(core_clk), .nrst(nrst), .link(tsi_link_if_inst),
        .side_data(side_data), .side_valid(side_valid), .side_ready(side_ready),
        .out_word(out_word), .out_valid(out_valid), .out_is_side(out_is_side),
        .read_ok(read_ok), .download_ok(download_ok), .event_count(event_count));
    tsi_link_chk tsi_link_chk_inst (.core_clk(core_clk), .nrst(nrst),
        .link_clk(tsi_link_if_inst.link_clk),
        .first_level_keep(tsi_link_if_inst.first_level_keep),
        .abort_clear(tsi_link_if_inst.abort_clear), .trig_keep(tsi_link_if_inst.trig_keep),
        .trig_reject(tsi_link_if_inst.trig_reject));

    // Core clock at 20 MHz and a free-running cycle count for deadlines.
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc_cnt <= cyc_cnt + 1;
    end

    // Words seen on the wire and at the intake output, sampled at link edges.
    always @(posedge tsi_link_if_inst.link_clk) begin
        link_edges <= link_edges + 1;
        if (tsi_link_if_inst.link_valid === 1'b1) wire_q.push_back(tsi_link_if_inst.link_word);
        if (out_valid === 1'b1 && out_is_side === 1'b0) seg_q.push_back(out_word);
        if (out_valid === 1'b1 && out_is_side === 1'b1) side_q.push_back(out_word);
    end

    task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Holds valid across words; a word is taken at an edge where ready is high.
    task automatic send_segs(input logic [1:0] layer, input logic [3:0] card,
                             input logic [47:0] base, input int n);
        int k;
        int w;
        @(posedge core_clk);
        seg_valid <= 1'b1;
        seg_layer <= layer;
        seg_card <= card;
        seg_word <= base;
        for (k = 0; k < n; k++) begin
            w = 0;
            do begin
                @(posedge core_clk);
                w++;
            end while (seg_ready !== 1'b1 && w < 50);
            seg_word <= base + 48'(k + 1);
        end
        seg_valid <= 1'b0;
    endtask : send_segs

    task automatic send_side(input logic [31:0] d);
        int w;
        @(posedge tsi_link_if_inst.link_clk);
        side_valid <= 1'b1;
        side_data <= d;
        w = 0;
        do begin
            @(posedge tsi_link_if_inst.link_clk);
            w++;
        end while (side_ready !== 1'b1 && w < 20);
        side_valid <= 1'b0;
    endtask : send_side

    // A clear ends the previous event first; a kept or rejected event waits for it.
    task automatic start_event;
        @(posedge core_clk);
        abort_req <= 1'b1;
        repeat (8) @(posedge core_clk);
        abort_req <= 1'b0;
        keep_req <= 1'b1;
        mark = cyc_cnt;
        repeat (8) @(posedge core_clk);
    endtask : start_event

    // Waits for the verdict pulse; the margin is one flop out, three back and the sampling edge.
    task automatic wait_verdict;
        int w;
        w = 0;
        do begin
            @(posedge core_clk);
            w++;
        end while (got_keep !== 1'b1 && got_reject !== 1'b1 && w < 500);
        kept = got_keep;
        check("late verdict", 48'h0, 48'(cyc_cnt - mark > tsi_pkg::DEADLINE_CYC + 5));
        keep_req <= 1'b0;
    endtask : wait_verdict

    task automatic pulse_run;
        run_req <= 1'b1;
        repeat (12) @(posedge core_clk);
        run_req <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask : pulse_run

    task automatic final_report;
        $display("errors %0d comparisons %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        $display("mismatch watchdog expected finish seen hang");
        final_report();
    end

    initial begin
        {nrst, seg_valid, keep_req, abort_req, run_req, side_valid} = 6'h00;
        {seg_word, seg_layer, seg_card, side_data} = '0;
        {num_errors, tests_run, cyc_cnt, link_edges} = '0;
        repeat (5) @(posedge core_clk);
        check("read_ok in reset", 48'h0, 48'(read_ok));
        check("out_valid in reset", 48'h0, 48'(out_valid));
        nrst <= 1'b1;
        repeat (8) @(posedge core_clk);
        pulse_run();
        check("download_ok", 48'h1, 48'(download_ok));
        check("event_count", 48'h0, 48'(event_count));
        // A segment with no open event is dropped; the link clock runs while idle.
        i = link_edges;
        send_segs(2'h0, 4'h0, 48'h0000000000A5, 1);
        repeat (16) @(posedge core_clk);
        check("dropped before keep", 48'h0, 48'(seg_q.size()));
        check("idle link clock", 48'h1, 48'(link_edges - i > 6));
        wire_q.delete();
        start_event();
        check("download_ok in event", 48'h0, 48'(download_ok));
        for (i = 0; i < 8; i++) begin
            seg_q.delete();
            send_segs(rows[i].layer, rows[i].card, rows[i].word, 1);
            repeat (16) @(posedge core_clk);
            check("accepted count", 48'(rows[i].accept), 48'(seg_q.size()));
            if (rows[i].accept) check("accepted word", rows[i].word, seg_q[0]);
        end
        check("wire words", 48'h8, 48'(wire_q.size()));
        check("wire zero word", 48'h0, wire_q[0]);
        send_side(32'hCAFE0001);
        send_side(32'hCAFE0002);
        repeat (16) @(posedge core_clk);
        check("side count", 48'h2, 48'(side_q.size()));
        check("side word 0", {16'h0000, 32'hCAFE0001}, side_q[0]);
        check("side word 1", {16'h0001, 32'hCAFE0002}, side_q[1]);
        wait_verdict();
        check("keep verdict", 48'h1, 48'(kept));
        repeat (4) @(posedge core_clk);
        check("read_ok after keep", 48'h1, 48'(read_ok));
        // Overflow on one card of layer zero; counters restart at the new keep.
        seg_q.delete();
        start_event();
        send_segs(2'h0, 4'h1, 48'h000000000100, 130);
        repeat (20) @(posedge core_clk);
        check("capped count", 48'h80, 48'(seg_q.size()));
        check("first kept", 48'h000000000100, seg_q[0]);
        check("last kept", 48'h00000000017F, seg_q[127]);
        wait_verdict();
        // Abort in mid-collection closes the event with a reject.
        start_event();
        for (i = 0; i < 4; i++) send_segs(2'(i), 4'h0, 48'h000000000777, 1);
        abort_req <= 1'b1;
        wait_verdict();
        check("abort verdict", 48'h0, 48'(kept));
        repeat (10) @(posedge core_clk);
        check("read_ok after abort", 48'h0, 48'(read_ok));
        abort_req <= 1'b0;
        repeat (10) @(posedge core_clk);
        check("event_count", 48'h3, 48'(event_count));
        pulse_run();
        check("event_count cleared", 48'h0, 48'(event_count));
        check("download_ok again", 48'h1, 48'(download_ok));
        final_report();
    end
endmodule : testbench
`default_nettype wire
